// ### bdpwm_pkg.sv
// Constants and carrier types for the battery converter pulse-width controller.
// Assumes a 200 MHz system clock and an APB master with 32-bit data.
package bdpwm_pkg;

   // Register indexes; the byte address is four times the index.
   localparam logic [7:0] IDX_POWER_DOWN   = 8'h0e;
   localparam logic [7:0] IDX_HEADROOM_RNG = 8'h42;
   localparam logic [7:0] IDX_HIGH_BAT     = 8'h4a;
   localparam logic [7:0] IDX_LOW_BAT      = 8'h4b;
   localparam logic [7:0] IDX_PERIOD       = 8'h5c;
   localparam logic [7:0] IDX_OFF_CAL      = 8'h5d;
   localparam logic [7:0] IDX_PULSE_WIDTH  = 8'h5e;
   localparam logic [7:0] IDX_ENHANCE      = 8'h6c;
   localparam logic [7:0] IDX_HEADROOM     = 8'h70;

   // Field positions.
   localparam int unsigned POWER_OFF_BIT   = 4;
   localparam int unsigned CAL_BIT         = 7;
   localparam int unsigned FAST_SETTLE_BIT = 5;
   localparam int unsigned LOOP_FILTER_BIT = 1;
   localparam int unsigned TRACK_BIT       = 6;
   localparam int unsigned RANGE_BIT       = 0;

   // Reset values; the converter starts powered down with the line open.
   localparam logic [7:0] POWER_DOWN_RST = 8'h10;
   localparam logic [7:0] REG_RST        = 8'h00;

   // Timing: converter steps of 61.035 ns come from a 16.384 MHz phase accumulator.
   localparam longint unsigned CLK_HZ     = 64'd200000000;
   localparam longint unsigned CONV_HZ    = 64'd16384000;
   localparam logic [31:0]     PHASE_STEP = 32'((CONV_HZ << 32) / CLK_HZ);
   localparam logic [7:0]      MIN_OFF_BASE = 8'h04;
   localparam int unsigned     CLK_PERIOD_PS = 5000;
   localparam int unsigned     CAL_TIME_NS   = 1280;
   localparam logic [8:0]      CAL_CYCLES    = 9'((CAL_TIME_NS * 1000) / CLK_PERIOD_PS);

   // Regulation constants, battery codes in 1.5 V steps.
   localparam logic [3:0] HEADROOM_MAX_LOW  = 4'h6;
   localparam logic [3:0] HEADROOM_MAX_HIGH = 4'h9;
   localparam logic [7:0] BAT_CODE_MAX      = 8'h3f;
   localparam logic [7:0] FAST_THRESH       = 8'h04;
   localparam logic [7:0] FAST_STEP         = 8'h04;
   localparam logic [2:0] FILTER_LIMIT      = 3'h3;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } bdpwm_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } bdpwm_apb_rsp_type;

   // Indications supplied by the linefeed and ringing logic.
   typedef struct packed {
      logic       ringing_burst;
      logic       constant_current;
      logic [5:0] cm_code;
      logic [5:0] feed_code;
   } bdpwm_line_type;

   typedef struct packed {
      logic [7:0]  power_down;
      logic [7:0]  headroom_range;
      logic [7:0]  high_bat;
      logic [7:0]  low_bat;
      logic [7:0]  period;
      logic [4:0]  min_off;
      logic [7:0]  enhance;
      logic [3:0]  headroom;
      logic        cal_busy;
      logic [8:0]  cal_cnt;
      logic        base_high;
      logic        base_low;
      logic [31:0] phase;
      logic [7:0]  cnt;
      logic [7:0]  ontime;
      logic [7:0]  pulse;
      logic signed [2:0] filt;
      logic        overload;
      logic        strap_taken;
      logic        same_polarity;
      logic        drive;
      logic        ff;
      logic [31:0] rdata;
   } bdpwm_state_type;

endpackage

// ### bdpwm_ctrl.sv
// Pulse-width controller for the negative battery buck-boost converter, with APB registers.
// Assumes line indications, battery sense and monitor levels are synchronous to clk.
//
// Functional notes
// - Converter stays off while the power-off bit is one; clearing it enables switching.
// - Standard variant drives feed-forward output inverted from primary drive.
// - Alternate variant drives feed-forward output with primary drive polarity.
// - Period comes from the 8-bit period field in 61.035 ns steps.
// - Primary switch output asserted for computed on-time, readable in pulse-width register.
// - Switch held off at least minimum-off field plus four converter clocks.
// - Overload from input monitors turns switch off for rest of period.
// - On-time lengthens below battery target and shortens above it.
// - Software sets calibration bit after power-on; bit reads calibration busy.
// - Headroom field and range bit add 1.5 V steps beyond the line.
// - Constant-current target is feed voltage plus common mode plus headroom.
// - In constant current without tracking, target never falls below the low-battery setting outside a ringing burst.
// - During a ringing burst target is the high-battery setting.
// - After a ringing burst target returns to active-state rules.
// - Fast-settle bit selects larger on-time steps for large errors.
// - Loop-filter bit averages error decisions to reject audio-band noise.
// - After reset the converter is powered down with the line open.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module bdpwm_ctrl
   import bdpwm_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // APB slave
   input  wire bdpwm_apb_req_type apb_req,
   output bdpwm_apb_rsp_type      apb_rsp,
   // Variant strap and line indications
   input  wire logic              feed_forward_same_polarity,
   input  wire bdpwm_line_type    line_state,
   // Sensing
   input  wire logic [5:0]        battery_sense_input,
   input  wire logic              input_monitor_high,
   input  wire logic              input_monitor_low,
   // Switch drive
   output logic                   primary_switch_drive,
   output logic                   feed_forward_switch_drive
);

   logic [1:0]      rst_sync_q;
   logic            rst_n;
   bdpwm_state_type s_q;
   bdpwm_state_type s_d;

   logic [7:0]  idx;
   logic        addr_ok;
   logic        wr_en;
   logic [32:0] ph_sum;
   logic        tick;
   logic        running;
   logic        overload_now;
   logic [7:0]  off_min;
   logic [7:0]  max_on;
   logic [7:0]  clamped;
   logic [3:0]  hr;
   logic [7:0]  sum;
   logic [7:0]  target;
   logic [7:0]  err;
   logic [7:0]  step;
   logic        want_up;
   logic        adjust;
   logic        period_end;
   logic [8:0]  on_up;

   // Reset is applied at once and released through two flip-flops.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   assign idx     = apb_req.paddr[9:2];
   assign addr_ok = (apb_req.paddr[1:0] == 2'b00) && (apb_req.paddr[11:10] == 2'b00) &&
                    (idx == IDX_POWER_DOWN || idx == IDX_HEADROOM_RNG ||
                     idx == IDX_HIGH_BAT || idx == IDX_LOW_BAT || idx == IDX_PERIOD ||
                     idx == IDX_OFF_CAL || idx == IDX_PULSE_WIDTH || idx == IDX_ENHANCE ||
                     idx == IDX_HEADROOM);
   assign wr_en   = apb_req.psel && apb_req.penable && apb_req.pwrite && addr_ok;

   // Zero wait states: read data is captured in the setup cycle.
   assign apb_rsp = '{prdata:  s_q.rdata,
                      pready:  1'b1,
                      pslverr: apb_req.psel && apb_req.penable && !addr_ok};

   function automatic logic [31:0] read_mux(input bdpwm_state_type st, input logic [7:0] i);
      logic [7:0] v;
      v = 8'h00;
      case (i)
         IDX_POWER_DOWN:   v = st.power_down;
         IDX_HEADROOM_RNG: v = st.headroom_range;
         IDX_HIGH_BAT:     v = st.high_bat;
         IDX_LOW_BAT:      v = st.low_bat;
         IDX_PERIOD:       v = st.period;
         IDX_OFF_CAL:      v = {st.cal_busy, 2'b00, st.min_off};
         IDX_PULSE_WIDTH:  v = st.pulse;
         IDX_ENHANCE:      v = st.enhance;
         IDX_HEADROOM:     v = {4'h0, st.headroom};
         default:          v = 8'h00;
      endcase
      return {24'h000000, v};
   endfunction

   // Converter clock enable from a phase accumulator; jitter is one system clock.
   assign ph_sum = {1'b0, s_q.phase} + {1'b0, PHASE_STEP};
   assign tick   = ph_sum[32];

   assign running = !s_q.power_down[POWER_OFF_BIT] && !s_q.cal_busy && (s_q.period != 8'h00);

   assign overload_now = (input_monitor_high ^ s_q.base_high) |
                         (input_monitor_low ^ s_q.base_low);

   assign off_min = {3'b000, s_q.min_off} + MIN_OFF_BASE;
   assign max_on  = (s_q.period > off_min) ? (s_q.period - off_min) : 8'h00;
   assign clamped = (s_q.ontime > max_on) ? max_on : s_q.ontime;

   always_comb begin
      if (s_q.headroom_range[RANGE_BIT]) begin
         hr = (s_q.headroom > HEADROOM_MAX_HIGH) ? HEADROOM_MAX_HIGH : s_q.headroom;
      end else begin
         hr = (s_q.headroom > HEADROOM_MAX_LOW) ? HEADROOM_MAX_LOW : s_q.headroom;
      end
   end

   assign sum = {2'b00, line_state.cm_code} + {2'b00, line_state.feed_code} + {4'h0, hr};

   always_comb begin
      target = (sum > BAT_CODE_MAX) ? BAT_CODE_MAX : sum;
      if (line_state.constant_current && !s_q.enhance[TRACK_BIT] &&
          target < {2'b00, s_q.low_bat[5:0]}) begin
         target = {2'b00, s_q.low_bat[5:0]};
      end
      if (line_state.ringing_burst) begin
         target = {2'b00, s_q.high_bat[5:0]};
      end
   end

   assign want_up = {2'b00, battery_sense_input} < target;
   assign err     = want_up ? (target - {2'b00, battery_sense_input})
                            : ({2'b00, battery_sense_input} - target);

   assign step = (s_q.enhance[FAST_SETTLE_BIT] && err >= FAST_THRESH) ? FAST_STEP : 8'h01;

   assign period_end = tick && (s_q.cnt >= s_q.period - 8'h01);
   assign on_up      = {1'b0, s_q.ontime} + {1'b0, step};

   always_comb begin
      s_d    = s_q;
      adjust = 1'b0;
      s_d.phase = ph_sum[31:0];

      // Strap captured once, after reset release.
      if (!s_q.strap_taken) begin
         s_d.strap_taken   = 1'b1;
         s_d.same_polarity = feed_forward_same_polarity;
      end

      if (apb_req.psel && !apb_req.penable) begin
         s_d.rdata = read_mux(s_q, idx);
      end

      if (s_q.cal_busy) begin
         if (s_q.cal_cnt == 9'h000) begin
            s_d.cal_busy  = 1'b0;
            s_d.base_high = input_monitor_high;
            s_d.base_low  = input_monitor_low;
         end else begin
            s_d.cal_cnt = s_q.cal_cnt - 9'h001;
         end
      end

      if (wr_en) begin
         case (idx)
            IDX_POWER_DOWN:   s_d.power_down = apb_req.pwdata[7:0];
            IDX_HEADROOM_RNG: s_d.headroom_range = apb_req.pwdata[7:0];
            IDX_HIGH_BAT:     s_d.high_bat = apb_req.pwdata[7:0];
            IDX_LOW_BAT:      s_d.low_bat = apb_req.pwdata[7:0];
            IDX_PERIOD:       s_d.period = apb_req.pwdata[7:0];
            IDX_OFF_CAL: begin
               s_d.min_off = apb_req.pwdata[4:0];
               // A start written as calibration ends restarts it.
               if (apb_req.pwdata[CAL_BIT]) begin
                  s_d.cal_busy = 1'b1;
                  s_d.cal_cnt  = CAL_CYCLES - 9'h001;
               end
            end
            IDX_ENHANCE:      s_d.enhance = apb_req.pwdata[7:0];
            IDX_HEADROOM:     s_d.headroom = apb_req.pwdata[3:0];
            default:          s_d.enhance = s_q.enhance;
         endcase
      end

      if (!running) begin
         s_d.cnt      = 8'h00;
         s_d.overload = 1'b0;
         s_d.pulse    = clamped;
         s_d.filt     = 3'sd0;
         if (s_q.power_down[POWER_OFF_BIT]) begin
            s_d.ontime = 8'h00;
         end
      end else begin
         if (overload_now) begin
            s_d.overload = 1'b1;
         end
         if (period_end) begin
            s_d.cnt      = 8'h00;
            s_d.overload = 1'b0;
            if (s_q.enhance[LOOP_FILTER_BIT]) begin
               if (want_up && s_q.filt == $signed(FILTER_LIMIT)) begin
                  adjust = 1'b1;
                  s_d.filt = 3'sd0;
               end else if (!want_up && s_q.filt == -$signed(FILTER_LIMIT)) begin
                  adjust = 1'b1;
                  s_d.filt = 3'sd0;
               end else begin
                  s_d.filt = want_up ? s_q.filt + 3'sd1 : s_q.filt - 3'sd1;
               end
            end else begin
               adjust = 1'b1;
            end
            if (adjust) begin
               if (want_up) begin
                  s_d.ontime = on_up[8] ? 8'hff : on_up[7:0];
               end else begin
                  s_d.ontime = (s_q.ontime > step) ? s_q.ontime - step : 8'h00;
               end
            end
            s_d.pulse = clamped;
         end else if (tick) begin
            s_d.cnt = s_q.cnt + 8'h01;
         end
      end

      // overload cut
      // The live bound also covers a pulse latched before the minimum off time was raised.
      s_d.drive = running && (s_d.cnt < s_d.pulse) && (s_d.cnt < max_on) &&
                  !s_d.overload && !overload_now;
      s_d.ff = s_d.same_polarity ? s_d.drive : !s_d.drive;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{power_down: POWER_DOWN_RST, headroom_range: REG_RST, ff: 1'b1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign primary_switch_drive      = s_q.drive;
   assign feed_forward_switch_drive = s_q.ff;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence cal_started;
      wr_en && idx == IDX_OFF_CAL && apb_req.pwdata[CAL_BIT];
   endsequence

   sequence cal_hold;
      s_q.cal_busy [*8];
   endsequence

   chk_power_off_quiet: assert property (
      s_q.power_down[POWER_OFF_BIT] |=> !primary_switch_drive)
      else $error("switch drive while powered down");

   chk_ff_inverted: assert property (
      s_q.strap_taken && !s_q.same_polarity |->
         feed_forward_switch_drive == !primary_switch_drive)
      else $error("feed-forward not inverted");

   chk_ff_same_pol: assert property (
      s_q.strap_taken && s_q.same_polarity |->
         feed_forward_switch_drive == primary_switch_drive)
      else $error("feed-forward polarity differs");

   chk_period_wrap: assert property (
      running && period_end && !wr_en |=> s_q.cnt == 8'h00)
      else $error("period counter did not wrap");

   chk_pulse_bound: assert property (
      primary_switch_drive |-> s_q.cnt < s_q.pulse)
      else $error("drive beyond pulse width");

   chk_min_off_fit: assert property (
      running && $past(running) && $past(period_end) && !$past(wr_en) |->
         ({1'b0, s_q.pulse} + {1'b0, off_min} <= {1'b0, s_q.period}) || s_q.pulse == 8'h00)
      else $error("on-time plus minimum off exceeds period");

   chk_overload_cut: assert property (
      running && overload_now && !period_end |=> !primary_switch_drive ##1
         (!primary_switch_drive || $past(period_end)))
      else $error("overload did not hold switch off");

   chk_cal_busy: assert property (
      cal_started |=> cal_hold ##[1:300] !s_q.cal_busy)
      else $error("calibration busy window wrong");

   chk_ring_target: assert property (
      line_state.ringing_burst |-> target == {2'b00, s_q.high_bat[5:0]})
      else $error("ringing target not high battery");

   chk_track_floor: assert property (
      !line_state.ringing_burst && line_state.constant_current && !s_q.enhance[TRACK_BIT]
         |-> target >= {2'b00, s_q.low_bat[5:0]})
      else $error("target below low battery without tracking");

   chk_cal_quiet: assert property (
      s_q.cal_busy |=> !primary_switch_drive)
      else $error("switch drive during calibration");

   chk_off_gap: assert property (
      running && !period_end && s_q.cnt >= max_on |=> !primary_switch_drive)
      else $error("switch on inside minimum off time");

   chk_ontime_clear: assert property (
      s_q.power_down[POWER_OFF_BIT] |=> s_q.ontime == 8'h00)
      else $error("on-time kept while powered down");

   chk_fast_step: assert property (
      running && period_end && want_up && s_q.enhance[FAST_SETTLE_BIT] &&
         !s_q.enhance[LOOP_FILTER_BIT] && err >= FAST_THRESH && s_q.ontime < 8'hfc
         |=> s_q.ontime == $past(s_q.ontime) + FAST_STEP)
      else $error("fast settle step not taken");

   chk_filter_wait: assert property (
      running && period_end && want_up && s_q.enhance[LOOP_FILTER_BIT] &&
         s_q.filt != $signed(FILTER_LIMIT) |=> $stable(s_q.ontime))
      else $error("on-time stepped before filter agreed");

   chk_headroom_cap: assert property (
      hr <= (s_q.headroom_range[RANGE_BIT] ? HEADROOM_MAX_HIGH : HEADROOM_MAX_LOW))
      else $error("headroom beyond range limit");

endmodule

// ### bdpwm_stage.sv
// Behavioural power stage: battery sense divider and input monitors.
// Assumes the bench commands the battery level and overload faults at clock edges.
`timescale 1ns/1ps
module bdpwm_stage (
   // Clock
   input  wire logic       clk,
   // Bench commands
   input  wire logic [5:0] vbat_level,
   input  wire logic [1:0] overload_cmd,
   // Sense outputs
   output logic [5:0]      battery_sense_input,
   output logic            input_monitor_high,
   output logic            input_monitor_low
);
   initial begin
      battery_sense_input = 6'h00;
      input_monitor_high  = 1'b0;
      input_monitor_low   = 1'b0;
   end
   // The divider is filtered, so the sensed level lags the battery by a clock.
   always @(posedge clk) begin
      battery_sense_input <= vbat_level;
   end
   always @(posedge clk) begin
      input_monitor_high <= overload_cmd[0];
      input_monitor_low  <= overload_cmd[1];
   end
endmodule

// ### bdpwm_ctrl_test.sv
// Self-checking bench for the battery converter pulse-width controller.
// Assumes bdpwm_stage stands in for the external sense network and input monitors.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_fail++; \
   $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module bdpwm_ctrl_test;
   import bdpwm_pkg::*;
   logic              clk        = 1'b0;
   logic              reset_n    = 1'b0;
   logic              strap      = 1'b0;
   logic              watch      = 1'b0;
   logic [5:0]        vbat       = 6'h00;
   logic [1:0]        ovl        = 2'h0;
   bdpwm_apb_req_type req        = '0;
   bdpwm_line_type    line       = '0;
   bdpwm_apb_rsp_type rsp;
   logic [5:0]        sense;
   logic              mon_h;
   logic              mon_l;
   logic              drv;
   logic              ff;
   logic [31:0]       rd;
   logic              err;
   int                n_fail     = 0;
   int                n_compared = 0;
   int                cycles     = 0;

   bdpwm_ctrl dut (.clk(clk), .reset_n(reset_n), .apb_req(req), .apb_rsp(rsp),
      .feed_forward_same_polarity(strap), .line_state(line), .battery_sense_input(sense),
      .input_monitor_high(mon_h), .input_monitor_low(mon_l),
      .primary_switch_drive(drv), .feed_forward_switch_drive(ff));
   bdpwm_stage stage (.clk(clk), .vbat_level(vbat), .overload_cmd(ovl),
      .battery_sense_input(sense), .input_monitor_high(mon_h), .input_monitor_low(mon_l));

   always #2.5 clk = ~clk;

   // The whole run needs about 45000 cycles; the ceiling leaves margin.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 80000) begin
         n_fail++;
         print_verdict();
      end
   end

   always @(negedge clk) begin
      if (watch) `CHK("ff polarity", strap ? drv : ~drv, ff)
   end

   task automatic print_verdict;
      $display("compared %0d mismatched %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge clk);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= wr;
      req.paddr   <= {2'h0, idx, 2'h0};
      req.pwdata  <= {24'h0, wd};
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic do_reset(input logic variant);
      watch = 1'b0;
      strap   <= variant;
      reset_n <= 1'b0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      watch = 1'b1;
   endtask

   task automatic periods(input int n);
      repeat (n * 250) @(posedge clk);
   endtask

   // Waits for a fresh rising edge of the drive, never the middle of a pulse.
   task automatic wait_rise;
      for (int k = 0; k < 400 && drv !== 1'b0; k++) @(posedge clk);
      for (int k = 0; k < 400 && drv !== 1'b1; k++) @(posedge clk);
   endtask

   task automatic t_reset;
      apb(1'b0, IDX_POWER_DOWN, 8'h00);
      `CHK("power down", 32'h00000010, rd)
      apb(1'b0, IDX_PERIOD, 8'h00);
      `CHK("period", 32'h00000000, rd)
      `CHK("drive idle", 1'b0, drv)
      apb(1'b1, 8'h5e, 8'h55);
      `CHK("ro write err", 1'b0, err)
      apb(1'b0, IDX_PULSE_WIDTH, 8'h00);
      `CHK("ro pulse", 32'h00000000, rd)
      apb(1'b0, 8'h01, 8'h00);
      `CHK("unmapped err", 1'b1, err)
      `CHK("unmapped data", 32'h00000000, rd)
      $display("test reset done");
   endtask

   task automatic t_clamp;
      int h;
      line.cm_code   <= 6'h04;
      line.feed_code <= 6'h04;
      apb(1'b1, IDX_PERIOD, 8'h14);
      apb(1'b1, IDX_OFF_CAL, 8'h1f);
      apb(1'b1, IDX_POWER_DOWN, 8'h00);
      periods(3);
      apb(1'b0, IDX_PULSE_WIDTH, 8'h00);
      `CHK("no room pulse", 32'h00000000, rd)
      `CHK("no room drive", 1'b0, drv)
      apb(1'b1, IDX_OFF_CAL, 8'h00);
      periods(20);
      apb(1'b0, IDX_PULSE_WIDTH, 8'h00);
      `CHK("full pulse", 32'h00000010, rd)
      apb(1'b1, IDX_OFF_CAL, 8'h02);
      periods(2);
      apb(1'b0, IDX_PULSE_WIDTH, 8'h00);
      `CHK("clamped pulse", 32'h0000000e, rd)
      wait_rise();
      h = 0;
      while (drv === 1'b1 && h < 400) begin
         @(posedge clk);
         h++;
      end
      // Fourteen ticks of about 12.2 clocks each.
      `CHK("on clocks", 1'b1, h >= 168 && h <= 173)
      $display("test clamp done");
   endtask

   task automatic t_cal;
      apb(1'b1, IDX_OFF_CAL, 8'h82);
      apb(1'b0, IDX_OFF_CAL, 8'h00);
      `CHK("cal busy", 1'b1, rd[7])
      repeat (5) @(posedge clk);
      `CHK("cal drive", 1'b0, drv)
      repeat (300) @(posedge clk);
      apb(1'b0, IDX_OFF_CAL, 8'h00);
      `CHK("cal done", 32'h00000002, rd)
      $display("test cal done");
   endtask

   task automatic t_overload;
      for (int i = 0; i < 2; i++) begin
         wait_rise();
         ovl[i] <= 1'b1;
         repeat (3) @(posedge clk);
         `CHK("cut drive", 1'b0, drv)
         repeat (100) @(posedge clk);
         `CHK("rest of period", 1'b0, drv)
         ovl <= 2'h0;
         wait_rise();
         `CHK("next period", 1'b1, drv)
      end
      apb(1'b1, IDX_POWER_DOWN, 8'h10);
      periods(1);
      `CHK("off drive", 1'b0, drv)
      apb(1'b0, IDX_PULSE_WIDTH, 8'h00);
      `CHK("off pulse", 32'h00000000, rd)
      $display("test overload done");
   endtask

   task automatic t_target;
      logic [3:0] cs [6];
      int         tgt;
      cs = '{4'b0000, 4'b0001, 4'b0100, 4'b0110, 4'b1110, 4'b0110};
      vbat <= 6'h0f;
      apb(1'b1, IDX_HEADROOM, 8'h0f);
      apb(1'b1, IDX_LOW_BAT, 8'h1e);
      // high setting kept above the ringing amplitude
      apb(1'b1, IDX_HIGH_BAT, 8'h28);
      apb(1'b1, IDX_POWER_DOWN, 8'h00);
      for (int i = 0; i < 6; i++) begin
         line.ringing_burst    <= cs[i][3];
         line.constant_current <= cs[i][2];
         apb(1'b1, IDX_ENHANCE, {1'b0, cs[i][1], 6'h00});
         apb(1'b1, IDX_HEADROOM_RNG, {7'h00, cs[i][0]});
         // Power cycling clears the on-time, so every case starts from zero.
         apb(1'b1, IDX_POWER_DOWN, 8'h10);
         apb(1'b1, IDX_POWER_DOWN, 8'h00);
         tgt = 8 + (cs[i][0] ? 9 : 6);
         if (cs[i][2] && !cs[i][1] && tgt < 30)
            tgt = 30;
         if (cs[i][3])
            tgt = 40;
         periods(20);
         apb(1'b0, IDX_PULSE_WIDTH, 8'h00);
         // Period 20 less a minimum off of 2 plus 4 leaves room for 14.
         `CHK("regulated pulse", tgt > 15 ? 32'h0e : 32'h0, rd)
      end
      apb(1'b1, IDX_ENHANCE, 8'h60);
      line.ringing_burst <= 1'b1;
      periods(3);
      apb(1'b0, IDX_PULSE_WIDTH, 8'h00);
      `CHK("fast settle", 1'b1, rd >= 32'h8)
      // With the filter, four agreeing periods make one step: eight periods give one or two.
      apb(1'b1, IDX_POWER_DOWN, 8'h10);
      apb(1'b1, IDX_ENHANCE, 8'h02);
      apb(1'b1, IDX_POWER_DOWN, 8'h00);
      periods(8);
      apb(1'b0, IDX_PULSE_WIDTH, 8'h00);
      `CHK("filtered pulse", 1'b1, rd >= 32'h1 && rd <= 32'h2)
      $display("test target done");
   endtask

   task automatic t_variant;
      do_reset(1'b1);
      // A target above the sensed level makes the alternate variant switch.
      line <= '{1'b0, 1'b0, 6'h04, 6'h04};
      vbat <= 6'h00;
      apb(1'b1, IDX_PERIOD, 8'h14);
      apb(1'b1, IDX_POWER_DOWN, 8'h00);
      periods(4);
      wait_rise();
      `CHK("alt running", 1'b1, drv)
      `CHK("alt ff", 1'b1, ff)
      $display("test variant done");
   endtask

   initial begin
      do_reset(1'b0);
      t_reset();
      t_clamp();
      t_cal();
      t_overload();
      t_target();
      t_variant();
      print_verdict();
   end
endmodule
